//--- core/clock_synth_power_control.sv
/*
  Clock source selection and power gating control. Holds the pll control and
  power control registers, sequences glitch-free source switches and drives
  gate enables for the core clock and peripheral clocks.
  Assumes the analog pll, ring oscillator, reference oscillator and clock gate
  cells sit outside and obey the enables; all inputs synchronous to CORE_CLK.
*/
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
// Function
// - after reset the core clock comes from the reference input
// - setting synth select moves the source to the pll clock without glitch
// - lock flag sets once the pll locks, then lock detection is disabled
// - any write to pll control clears the lock flag; a write in the same cycle as an armed lock detection leaves it set
// - vco equals reference times M over N; core clock is vco halved
// - M coded as M-2; N coded as N-2, with N of one coded seven
// - synth power enable clear powers the pll down, set powers it up
// - select clear uses reference clock, select set uses the pll clock
// - reset clears pll control: pll deselected and powered down
// - switch to pll within 1..N+2 cycles, back within M/N+1..M+M/N+1
// - power control overrides pll selection: stop clock or force ring clock
// - oscillator off powers down the oscillator and stops the core clock unless the ring clock is active
// - ring select uses the ring oscillator, powered while selected and until the ring clock is released
// - clock halt stops the core clock for any source; pll keeps running
// - enabled interrupt pins clear clock halt; reset also clears it
// - three gate bits cut clocks to serial one, serial two, host port
// - timer gate bit disables the timer clock; writing zero restarts it
// - power control register holds ten bits
// - stop pin low acts as clock halt; clock resumes when pin returns high
// - reset assertion clears oscillator off, restoring oscillator power
`timescale 1ns/1ps
`default_nettype none
module clock_synth_power_control (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PLL_LOCK_DETECT,
  input wire logic IRQ0_PIN,
  input wire logic IRQ1_PIN,
  input wire logic STOP_PIN_N,
  output logic PLL_POWER_EN,
  output logic [4:0] PLL_M_BITS,
  output logic [2:0] PLL_N_BITS,
  output logic [3:0] PLL_LF_BITS,
  output logic LOCK_DETECT_EN,
  output logic OSC_POWER_EN,
  output logic RING_OSC_POWER_EN,
  output logic [clk_pwr_pkg::SRC_SEL_RING:0] CORE_CLK_SRC,
  output logic CORE_CLK_RUN,
  output logic SERIAL_ONE_CLK_EN,
  output logic SERIAL_TWO_CLK_EN,
  output logic HOST_PORT_CLK_EN,
  output logic TIMER_CLK_EN
);
  import clk_pwr_pkg::*;

  // decoded divider values
  function automatic logic [5:0] decode_n(input logic [2:0] nbits);
    if (nbits == N_CODE_ONE) begin
      decode_n = 6'h01;
    end else begin
      decode_n = {3'h0, nbits} + DIV_OFFSET;
    end
  endfunction

  function automatic logic [5:0] decode_m(input logic [4:0] mbits);
    decode_m = {1'b0, mbits} + DIV_OFFSET;
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old_v;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    merge_lanes = v & mask;
  endfunction

  logic [15:0] pll_ctrl_r;
  logic [15:0] pwr_ctrl_r;
  logic lock_flag_r;
  logic lock_armed_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic pll_wr;
  logic pwr_wr;
  logic wake;
  src_state_e src_r;
  logic [5:0] sw_cnt_r;
  logic [1:0] ring_cnt_r;
  logic ring_active_r;
  logic [5:0] n_val;
  logic [5:0] m_val;
  logic [5:0] m_over_n;
  logic pll_sel;
  logic core_run;
  logic [1:0] src_sel;
  logic [31:0] rd_word;
  logic rd_ok;

  assign n_val = decode_n(pll_ctrl_r[PLL_N_LSB +: 3]);
  assign m_val = decode_m(pll_ctrl_r[PLL_M_LSB +: 5]);
  assign m_over_n = m_val / n_val;
  assign pll_sel = pll_ctrl_r[PLL_SEL_BIT];

  // write path: address and data taken in either order
  assign wr_fire = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  assign pll_wr = wr_fire && (aw_addr_r == ADDR_PLL_CTRL);
  assign pwr_wr = wr_fire && (aw_addr_r == ADDR_PWR_CTRL);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
    end else if (CLK_EN) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_AWREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (CLK_EN) begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        if (pll_wr || pwr_wr || aw_addr_r == ADDR_STATUS) begin
          S_AXI_BRESP <= RESP_OKAY;
        end else begin
          S_AXI_BRESP <= RESP_SLVERR;
        end
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // pll control register; the lock bit position is not stored
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pll_ctrl_r <= PLL_CTRL_RST;
    end else if (CLK_EN) begin
      if (pll_wr) begin
        pll_ctrl_r <= merge_lanes(pll_ctrl_r, w_data_r, w_strb_r, PLL_CTRL_MASK);
      end
    end
  end

  // lock flag: set by the detector while armed, cleared and re-armed by a write
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_flag_r <= 1'b0;
      lock_armed_r <= 1'b1;
    end else if (CLK_EN) begin
      if (lock_armed_r && PLL_LOCK_DETECT && pll_ctrl_r[PLL_EN_BIT]) begin
        lock_flag_r <= 1'b1;
        lock_armed_r <= 1'b0;
      end else if (pll_wr) begin
        lock_flag_r <= 1'b0;
        lock_armed_r <= 1'b1;
      end
    end
  end

  // power control register; wake and reset clear halt
  assign wake = (IRQ0_PIN && pwr_ctrl_r[PWR_IRQ0_WAKE_BIT]) ||
                (IRQ1_PIN && pwr_ctrl_r[PWR_IRQ1_WAKE_BIT]);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_ctrl_r <= PWR_CTRL_RST;
    end else if (CLK_EN) begin
      if (pwr_wr) begin
        pwr_ctrl_r <= merge_lanes(pwr_ctrl_r, w_data_r, w_strb_r, PWR_CTRL_MASK);
      end
      if (wake) begin
        pwr_ctrl_r[PWR_HALT_BIT] <= 1'b0;
      end
    end
  end

  // reference / pll switch, synchronous with bounded latency
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_r <= SW_REF;
      sw_cnt_r <= 6'h0;
    end else if (CLK_EN) begin
      case (src_r)
        SW_REF: begin
          if (pll_sel) begin
            src_r <= SW_TO_PLL;
            sw_cnt_r <= n_val - 6'h01;
          end
        end
        SW_TO_PLL: begin
          if (!pll_sel) begin
            src_r <= SW_REF;
          end else if (sw_cnt_r == 6'h0) begin
            src_r <= SW_PLL;
          end else begin
            sw_cnt_r <= sw_cnt_r - 6'h01;
          end
        end
        SW_PLL: begin
          if (!pll_sel) begin
            src_r <= SW_TO_REF;
            sw_cnt_r <= m_over_n;
          end
        end
        SW_TO_REF: begin
          if (sw_cnt_r == 6'h0) begin
            src_r <= SW_REF;
          end else begin
            sw_cnt_r <= sw_cnt_r - 6'h01;
          end
        end
        default: begin
          src_r <= SW_REF;
        end
      endcase
    end
  end

  // ring oscillator: powered first, taken over after settling, released before power off
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ring_cnt_r <= 2'h0;
      ring_active_r <= 1'b0;
      RING_OSC_POWER_EN <= 1'b0;
    end else if (CLK_EN) begin
      RING_OSC_POWER_EN <= pwr_ctrl_r[PWR_RING_SEL_BIT] || ring_active_r;
      if (!pwr_ctrl_r[PWR_RING_SEL_BIT]) begin
        ring_active_r <= 1'b0;
        ring_cnt_r <= 2'h0;
      end else if (RING_OSC_POWER_EN && ring_cnt_r == RING_SETTLE_CYC) begin
        ring_active_r <= 1'b1;
      end else if (RING_OSC_POWER_EN) begin
        ring_cnt_r <= ring_cnt_r + 2'h1;
      end
    end
  end

  // clock source and gating priority
  always_comb begin
    if (ring_active_r) begin
      src_sel = SRC_SEL_RING;
    end else if (src_r == SW_PLL || src_r == SW_TO_REF) begin
      src_sel = SRC_SEL_PLL;
    end else begin
      src_sel = SRC_SEL_REF;
    end
  end

  assign core_run = !pwr_ctrl_r[PWR_HALT_BIT] && STOP_PIN_N &&
                    !(pwr_ctrl_r[PWR_OSC_OFF_BIT] && !ring_active_r);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_CLK_SRC <= {1'b0, SRC_SEL_REF};
      CORE_CLK_RUN <= 1'b1;
      OSC_POWER_EN <= 1'b1;
      SERIAL_ONE_CLK_EN <= 1'b1;
      SERIAL_TWO_CLK_EN <= 1'b1;
      HOST_PORT_CLK_EN <= 1'b1;
      TIMER_CLK_EN <= 1'b1;
    end else if (CLK_EN) begin
      CORE_CLK_SRC <= {1'b0, src_sel};
      CORE_CLK_RUN <= core_run;
      OSC_POWER_EN <= !pwr_ctrl_r[PWR_OSC_OFF_BIT];
      SERIAL_ONE_CLK_EN <= core_run && !pwr_ctrl_r[PWR_SER1_GATE_BIT];
      SERIAL_TWO_CLK_EN <= core_run && !pwr_ctrl_r[PWR_SER2_GATE_BIT];
      HOST_PORT_CLK_EN <= core_run && !pwr_ctrl_r[PWR_HOST_GATE_BIT];
      TIMER_CLK_EN <= core_run && !pwr_ctrl_r[PWR_TIMER_GATE_BIT];
    end
  end

  // pll drive: halt does not touch these, so the pll keeps running
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PLL_POWER_EN <= 1'b0;
      PLL_M_BITS <= 5'h0;
      PLL_N_BITS <= 3'h0;
      PLL_LF_BITS <= 4'h0;
      LOCK_DETECT_EN <= 1'b0;
    end else if (CLK_EN) begin
      PLL_POWER_EN <= pll_ctrl_r[PLL_EN_BIT];
      PLL_M_BITS <= pll_ctrl_r[PLL_M_LSB +: 5];
      PLL_N_BITS <= pll_ctrl_r[PLL_N_LSB +: 3];
      PLL_LF_BITS <= pll_ctrl_r[PLL_LF_LSB +: 4];
      LOCK_DETECT_EN <= lock_armed_r && pll_ctrl_r[PLL_EN_BIT];
    end
  end

  // read path
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR == ADDR_PLL_CTRL) begin
      rd_word[15:0] = pll_ctrl_r;
      rd_word[PLL_LOCK_BIT] = lock_flag_r;
    end else if (S_AXI_ARADDR == ADDR_PWR_CTRL) begin
      rd_word[15:0] = pwr_ctrl_r;
    end else if (S_AXI_ARADDR == ADDR_STATUS) begin
      rd_word[STAT_LOCK_BIT] = lock_flag_r;
      rd_word[STAT_SRC_LSB +: 2] = CORE_CLK_SRC[1:0];
      rd_word[STAT_RUN_BIT] = CORE_CLK_RUN;
      rd_word[STAT_BUSY_BIT] = (src_r == SW_TO_PLL) || (src_r == SW_TO_REF);
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/clk_pwr_pkg.sv
/*
  Constants for the clock source and power control block: register offsets,
  field positions, reset values, switch timing and the source state encoding.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses in 4 bits.
*/
`default_nettype none
package clk_pwr_pkg;
  localparam logic [3:0] ADDR_PLL_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // pll control fields
  localparam int PLL_M_LSB = 0;
  localparam int PLL_N_LSB = 5;
  localparam int PLL_LF_LSB = 8;
  localparam int PLL_LOCK_BIT = 12;
  localparam int PLL_SEL_BIT = 14;
  localparam int PLL_EN_BIT = 15;
  localparam logic [15:0] PLL_CTRL_MASK = 16'hefff;
  localparam logic [15:0] PLL_CTRL_RST = 16'h0000;

  // power control fields, ten stored bits
  localparam int PWR_OSC_OFF_BIT = 15;
  localparam int PWR_RING_SEL_BIT = 14;
  localparam int PWR_HALT_BIT = 13;
  localparam int PWR_IRQ0_WAKE_BIT = 12;
  localparam int PWR_IRQ1_WAKE_BIT = 11;
  localparam int PWR_SER1_GATE_BIT = 7;
  localparam int PWR_SER2_GATE_BIT = 6;
  localparam int PWR_HOST_GATE_BIT = 5;
  localparam int PWR_TIMER_GATE_BIT = 4;
  localparam logic [15:0] PWR_CTRL_MASK = 16'hf8f8;
  localparam logic [15:0] PWR_CTRL_RST = 16'h0000;

  // status fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_SRC_LSB = 1;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;

  // divider coding
  localparam logic [2:0] N_CODE_ONE = 3'h7;
  localparam logic [5:0] DIV_OFFSET = 6'h02;

  localparam logic [1:0] RING_SETTLE_CYC = 2'h2;

  localparam logic [1:0] SRC_SEL_REF = 2'h0;
  localparam logic [1:0] SRC_SEL_PLL = 2'h1;
  localparam logic [1:0] SRC_SEL_RING = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SW_REF = 2'b00,
    SW_TO_PLL = 2'b01,
    SW_PLL = 2'b11,
    SW_TO_REF = 2'b10
  } src_state_e;
endpackage
`default_nettype wire

//--- verification/csp_properties.sv
/*
  Port assertions for the clock source and power control block.
  Assumes one clock domain; bound to every instance of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module csp_properties
  import clk_pwr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic PLL_LOCK_DETECT,
  input wire logic STOP_PIN_N,
  input wire logic PLL_POWER_EN,
  input wire logic [4:0] PLL_M_BITS,
  input wire logic LOCK_DETECT_EN,
  input wire logic OSC_POWER_EN,
  input wire logic RING_OSC_POWER_EN,
  input wire logic [clk_pwr_pkg::SRC_SEL_RING:0] CORE_CLK_SRC,
  input wire logic CORE_CLK_RUN
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence wr_taken_s;
    CLK_EN && S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence wr_answer_s;
    !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence
  reset_state_a: assert property (
    $rose(ARST_N) |-> CORE_CLK_SRC == {1'h0, SRC_SEL_REF} && OSC_POWER_EN && CORE_CLK_RUN
      && !PLL_POWER_EN && PLL_M_BITS == 5'h00) else $error("reset state wrong");
  stop_halts_a: assert property (
    CLK_EN && !STOP_PIN_N |=> !CORE_CLK_RUN) else $error("clock runs with stop pin low");
  lock_disarm_a: assert property (
    CLK_EN && LOCK_DETECT_EN && PLL_LOCK_DETECT |=> ##1 !LOCK_DETECT_EN) else $error("lock detect still armed");
  ring_power_a: assert property (
    CORE_CLK_SRC == {1'h0, SRC_SEL_RING} |-> RING_OSC_POWER_EN) else $error("ring selected unpowered");
  wr_answer_a: assert property (
    wr_taken_s |=> wr_answer_s) else $error("write answer timing wrong");
  wr_release_a: assert property (
    CLK_EN && S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write response not released");
  rd_answer_a: assert property (
    CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer timing wrong");
  rd_release_a: assert property (
    CLK_EN && S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read response not released");
endmodule
bind clock_synth_power_control csp_properties u_props (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PLL_LOCK_DETECT(PLL_LOCK_DETECT), .STOP_PIN_N(STOP_PIN_N),
  .PLL_POWER_EN(PLL_POWER_EN), .PLL_M_BITS(PLL_M_BITS), .LOCK_DETECT_EN(LOCK_DETECT_EN),
  .OSC_POWER_EN(OSC_POWER_EN), .RING_OSC_POWER_EN(RING_OSC_POWER_EN), .CORE_CLK_SRC(CORE_CLK_SRC),
  .CORE_CLK_RUN(CORE_CLK_RUN)
);
`default_nettype wire

//--- verification/clock_synth_power_control_tb.sv
/*
  Self-checking bench for the clock source and power control block.
  Drives the register bus and the pins directly; no far-side model.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_synth_power_control_tb;
  import clk_pwr_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic clk_en = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic lock_det = 1'h0, irq0 = 1'h0, irq1 = 1'h0, stop_n = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, pll_pwr, lock_en, osc_pwr, ring_pwr, run;
  logic ser1_en, ser2_en, host_en, tmr_en;
  logic [1:0] bresp, rresp;
  logic [4:0] m_bits;
  logic [2:0] n_bits, src;
  logic [3:0] lf_bits;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  clock_synth_power_control u_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PLL_LOCK_DETECT(lock_det), .IRQ0_PIN(irq0), .IRQ1_PIN(irq1), .STOP_PIN_N(stop_n),
    .PLL_POWER_EN(pll_pwr), .PLL_M_BITS(m_bits), .PLL_N_BITS(n_bits), .PLL_LF_BITS(lf_bits),
    .LOCK_DETECT_EN(lock_en), .OSC_POWER_EN(osc_pwr), .RING_OSC_POWER_EN(ring_pwr),
    .CORE_CLK_SRC(src), .CORE_CLK_RUN(run), .SERIAL_ONE_CLK_EN(ser1_en),
    .SERIAL_TWO_CLK_EN(ser2_en), .HOST_PORT_CLK_EN(host_en), .TIMER_CLK_EN(tmr_en)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(rdata, exp);
    chk(rresp, (a > ADDR_STATUS) ? RESP_SLVERR : RESP_OKAY);
  endtask
  task automatic t_reset;
    chk({osc_pwr, run, pll_pwr, src}, {3'h6, 1'h0, SRC_SEL_REF});
    rd(ADDR_PLL_CTRL, 32'h0);
    rd(ADDR_PWR_CTRL, 32'h0);
    rd(4'hc, 32'h0);
    wr(4'hc, 32'h1234, RESP_SLVERR);
    $display("reset state done");
  endtask
  task automatic t_pll;
    int k;
    wr(ADDR_PLL_CTRL, 32'h2912, RESP_OKAY);
    idle(2);
    chk({pll_pwr, m_bits, n_bits, lf_bits}, {1'h0, 5'h12, 3'h0, 4'h9});
    wr(ADDR_PLL_CTRL, 32'ha912, RESP_OKAY);
    idle(2);
    chk({pll_pwr, lock_en}, 2'h3);
    lock_det <= 1'h1;
    idle(3);
    chk(lock_en, 1'h0);
    rd(ADDR_STATUS, 32'h9);
    rd(ADDR_PLL_CTRL, 32'hb912);
    lock_det <= 1'h0;
    wr(ADDR_PLL_CTRL, 32'hb912, RESP_OKAY);
    rd(ADDR_PLL_CTRL, 32'ha912);
    lock_det <= 1'h1;
    idle(3);
    rd(ADDR_STATUS, 32'h9);
    wr(ADDR_PLL_CTRL, 32'he912, RESP_OKAY);
    k = 0;
    while (src !== {1'h0, SRC_SEL_PLL} && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk(k >= 1 && k <= 4, 1'h1);
    $display("pll select done");
  endtask
  task automatic t_ring;
    wr(ADDR_PWR_CTRL, 32'h4000, RESP_OKAY);
    idle(6);
    chk({ring_pwr, src}, {2'h2, SRC_SEL_RING});
    wr(ADDR_PWR_CTRL, 32'hc000, RESP_OKAY);
    idle(3);
    chk({osc_pwr, run}, 2'h1);
    wr(ADDR_PWR_CTRL, 32'h0, RESP_OKAY);
    idle(4);
    chk({ring_pwr, src}, {2'h0, SRC_SEL_PLL});
    $display("ring clock done");
  endtask
  task automatic wait_src(input logic [1:0] s, output int k);
    k = 0;
    while (src !== {1'h0, s} && k < 60) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic t_desel;
    int k;
    wr(ADDR_PLL_CTRL, 32'ha912, RESP_OKAY);
    k = 0;
    while (src !== {1'h0, SRC_SEL_REF} && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk(k >= 11 && k <= 31, 1'h1);
    wr(ADDR_PLL_CTRL, 32'ha9f2, RESP_OKAY);
    idle(3);
    rd(ADDR_STATUS, 32'h9);
    wr(ADDR_PLL_CTRL, 32'he9f2, RESP_OKAY);
    wait_src(SRC_SEL_PLL, k);
    chk(k >= 1 && k <= 3, 1'h1);
    wr(ADDR_PLL_CTRL, 32'ha9f2, RESP_OKAY);
    wait_src(SRC_SEL_REF, k);
    chk(k >= 21 && k <= 41, 1'h1);
    $display("pll deselect done");
  endtask
  task automatic t_halt;
    wr(ADDR_PWR_CTRL, 32'h3000, RESP_OKAY);
    idle(2);
    chk({run, pll_pwr}, 2'h1);
    irq1 <= 1'h1;
    idle(3);
    chk(run, 1'h0);
    irq1 <= 1'h0;
    irq0 <= 1'h1;
    idle(3);
    irq0 <= 1'h0;
    chk(run, 1'h1);
    rd(ADDR_PWR_CTRL, 32'h1000);
    stop_n <= 1'h0;
    idle(3);
    chk(run, 1'h0);
    stop_n <= 1'h1;
    idle(3);
    chk(run, 1'h1);
    clk_en <= 1'h0;
    stop_n <= 1'h0;
    idle(3);
    chk(run, 1'h1);
    clk_en <= 1'h1;
    idle(2);
    chk(run, 1'h0);
    stop_n <= 1'h1;
    idle(3);
    chk(run, 1'h1);
    $display("halt and wake done");
  endtask
  task automatic t_gates;
    logic [3:0] e;
    for (int i = PWR_TIMER_GATE_BIT; i <= PWR_SER1_GATE_BIT; i++) begin
      wr(ADDR_PWR_CTRL, 32'h1 << i, RESP_OKAY);
      idle(3);
      e = ~(4'h1 << (i - PWR_TIMER_GATE_BIT));
      chk({ser1_en, ser2_en, host_en, tmr_en}, e);
    end
    wr(ADDR_PWR_CTRL, 32'h07ff, RESP_OKAY);
    rd(ADDR_PWR_CTRL, 32'h00f8);
    wr(ADDR_PWR_CTRL, 32'h0, RESP_OKAY);
    idle(3);
    chk({ser1_en, ser2_en, host_en, tmr_en}, 4'hf);
    $display("peripheral gates done");
  endtask
  task automatic t_osc;
    wr(ADDR_PLL_CTRL, 32'h29f2, RESP_OKAY);
    wr(ADDR_PWR_CTRL, 32'h8000, RESP_OKAY);
    idle(3);
    chk({osc_pwr, run, pll_pwr}, 3'h0);
    wr(ADDR_PWR_CTRL, 32'hffff, RESP_OKAY);
    rd(ADDR_PWR_CTRL, 32'hf8f8);
    arst_n <= 1'h0;
    idle(2);
    chk(osc_pwr, 1'h1);
    arst_n <= 1'h1;
    rd(ADDR_PWR_CTRL, 32'h0);
    rd(ADDR_PLL_CTRL, 32'h0);
    $display("oscillator off done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_pll;
    t_ring;
    t_desel;
    t_halt;
    t_gates;
    t_osc;
    results;
  end
endmodule
`default_nettype wire
